// ==== design/emb_ram_params.svh ====
`ifndef EMB_RAM_PARAMS_SVH
`define EMB_RAM_PARAMS_SVH

`define EMB_REG_CTRL         12'h000
`define EMB_REG_PRELOAD_ADDR 12'h004
`define EMB_REG_PRELOAD_DATA 12'h008
`define EMB_REG_STATUS       12'h00c

`define EMB_CTRL_W        9
`define EMB_CTRL_RESET    9'h000
`define EMB_CTRL_SHAPE_LO 0
`define EMB_CTRL_SHAPE_HI 1
`define EMB_CTRL_DREG     2
`define EMB_CTRL_AREG     3
`define EMB_CTRL_OREG     4
`define EMB_CTRL_ROM      5
`define EMB_CTRL_BANK_LO  6
`define EMB_CTRL_BANK_HI  8

`define EMB_TOTAL_BITS    2048
`define EMB_BYTES         256
`define EMB_WCOUNT_RESET  16'h0000
`define EMB_PADDR_RESET   8'h00

`endif

// ==== design/emb_ram_pkg.sv ====
package emb_ram_pkg;
    typedef enum logic [1:0] {
        SHAPE_256X8,
        SHAPE_512X4,
        SHAPE_1024X2,
        SHAPE_2048X1
    } shape_e;
    typedef logic [7:0] byte_t;
endpackage : emb_ram_pkg

// ==== design/bypass_stage.sv ====
`timescale 1ns/1ps
module bypass_stage #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         use_reg,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] r;
    logic [W-1:0] next_r;

    always_comb begin
        next_r = ce ? d : r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // bypass path is combinational so the stage adds no latency when off
    assign q = use_reg ? r : d;
endmodule : bypass_stage

// ==== design/embedded_memory_block.sv ====
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "emb_ram_params.svh"
module embedded_memory_block (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  in_ce,
    input  wire logic                  out_ce,
    input  wire logic                  user_we,
    input  wire logic [2:0]            user_bank,
    input  wire logic [10:0]           user_addr,
    input  wire emb_ram_pkg::byte_t    user_wdata,
    output emb_ram_pkg::byte_t         user_rdata,
    output logic                       user_rvalid
);
    import emb_ram_pkg::*;

    byte_t                  mem [0:`EMB_BYTES-1];
    logic [`EMB_CTRL_W-1:0] ctrl;
    logic [`EMB_CTRL_W-1:0] next_ctrl;
    logic [7:0]             pre_addr;
    logic [7:0]             next_pre_addr;
    logic [15:0]            wcount;
    logic [15:0]            next_wcount;
    logic [31:0]            next_prdata;
    logic                   rd_ready;
    logic                   next_rd_ready;
    shape_e                 shape;
    logic                   mapped;
    logic                   apb_wr;
    logic                   pre_wr;
    logic [14:0]            a_q;
    byte_t                  d_q;
    logic                   a_we;
    logic [2:0]             a_bank;
    logic [10:0]            a_addr;
    logic                   hit;
    logic [7:0]             wbyte;
    byte_t                  rd_c;
    logic                   wr_go;
    logic [8:0]             o_q;

    function automatic logic [7:0] byte_index(shape_e s, logic [10:0] a);
        logic [7:0] r;
        r = a[7:0];
        unique case (s)
            SHAPE_256X8:  r = a[7:0];
            SHAPE_512X4:  r = a[8:1];
            SHAPE_1024X2: r = a[9:2];
            SHAPE_2048X1: r = a[10:3];
        endcase
        return r;
    endfunction : byte_index

    function automatic byte_t pick(byte_t b, shape_e s, logic [10:0] a);
        byte_t r;
        r = 8'h00;
        unique case (s)
            SHAPE_256X8:  r = b;
            SHAPE_512X4:  r = {4'h0, a[0] ? b[7:4] : b[3:0]};
            SHAPE_1024X2: r = {6'h00, b[{a[1:0], 1'b0} +: 2]};
            SHAPE_2048X1: r = {7'h00, b[a[2:0]]};
        endcase
        return r;
    endfunction : pick

    function automatic byte_t merge(byte_t old, byte_t wd, shape_e s, logic [10:0] a);
        byte_t r;
        r = old;
        unique case (s)
            SHAPE_256X8:  r = wd;
            SHAPE_512X4: begin
                if (a[0]) begin
                    r[7:4] = wd[3:0];
                end else begin
                    r[3:0] = wd[3:0];
                end
            end
            SHAPE_1024X2: r[{a[1:0], 1'b0} +: 2] = wd[1:0];
            SHAPE_2048X1: r[a[2:0]] = wd[0];
        endcase
        return r;
    endfunction : merge

    assign shape  = shape_e'(ctrl[`EMB_CTRL_SHAPE_HI:`EMB_CTRL_SHAPE_LO]);
    assign mapped = (paddr == `EMB_REG_CTRL) || (paddr == `EMB_REG_PRELOAD_ADDR) ||
                    (paddr == `EMB_REG_PRELOAD_DATA) || (paddr == `EMB_REG_STATUS);
    // read data is captured one cycle ahead so prdata comes from a flop
    assign pready  = ce && psel && penable && rd_ready;
    assign pslverr = pready && !mapped;
    assign apb_wr  = pready && pwrite && mapped;
    assign pre_wr  = apb_wr && (paddr == `EMB_REG_PRELOAD_DATA);

    always_comb begin
        next_ctrl     = ctrl;
        next_pre_addr = pre_addr;
        next_prdata   = prdata;
        next_rd_ready = rd_ready;
        if (ce) begin
            next_rd_ready = psel && !(penable && rd_ready);
            if (psel && !rd_ready) begin
                unique case (paddr)
                    `EMB_REG_CTRL:         next_prdata = {23'h0, ctrl};
                    `EMB_REG_PRELOAD_ADDR: next_prdata = {24'h0, pre_addr};
                    `EMB_REG_PRELOAD_DATA: next_prdata = {24'h0, mem[pre_addr]};
                    `EMB_REG_STATUS:       next_prdata = {16'h0, wcount};
                    default:               next_prdata = 32'h0000_0000;
                endcase
            end
            if (apb_wr && paddr == `EMB_REG_CTRL) begin
                next_ctrl = pwdata[`EMB_CTRL_W-1:0];
            end
            if (apb_wr && paddr == `EMB_REG_PRELOAD_ADDR) begin
                next_pre_addr = pwdata[7:0];
            end
            if (pre_wr) begin
                next_pre_addr = pre_addr + 8'h01; // streams a table in one pass
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= `EMB_CTRL_RESET;
            pre_addr <= `EMB_PADDR_RESET;
            prdata   <= 32'h0000_0000;
            rd_ready <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            pre_addr <= next_pre_addr;
            prdata   <= next_prdata;
            rd_ready <= next_rd_ready;
        end
    end

    // input side advances on in_ce, output side on out_ce
    bypass_stage #(.W(15)) u_addr_stage (
        .clk     (pclk),
        .rst_n   (presetn),
        .ce      (ce && in_ce),
        .use_reg (ctrl[`EMB_CTRL_AREG]),
        .d       ({user_we, user_bank, user_addr}),
        .q       (a_q)
    );

    bypass_stage #(.W(8)) u_data_stage (
        .clk     (pclk),
        .rst_n   (presetn),
        .ce      (ce && in_ce),
        .use_reg (ctrl[`EMB_CTRL_DREG]),
        .d       (user_wdata),
        .q       (d_q)
    );

    assign a_we   = a_q[14];
    assign a_bank = a_q[13:11];
    assign a_addr = a_q[10:0];
    // bank compare lets several blocks share one address bus in depth
    assign hit    = (a_bank == ctrl[`EMB_CTRL_BANK_HI:`EMB_CTRL_BANK_LO]);
    assign wbyte  = byte_index(shape, a_addr);
    // the edge itself is the strobe; rom mode locks out user writes
    assign wr_go  = ce && in_ce && a_we && hit && !ctrl[`EMB_CTRL_ROM];
    // read sees the array before this edge's write lands
    assign rd_c   = hit ? pick(mem[wbyte], shape, a_addr) : 8'h00;

    // storage is not reset: contents are undefined until written or preloaded
    always_ff @(posedge pclk) begin
        if (wr_go) begin
            mem[wbyte] <= merge(mem[wbyte], d_q, shape, a_addr);
        end
        if (ce && pre_wr) begin
            mem[pre_addr] <= pwdata[7:0];
        end
    end

    always_comb begin
        next_wcount = wr_go ? wcount + 16'h0001 : wcount;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcount <= `EMB_WCOUNT_RESET;
        end else begin
            wcount <= next_wcount;
        end
    end

    // zero on a miss so cascaded blocks can simply be or-ed together
    bypass_stage #(.W(9)) u_out_stage (
        .clk     (pclk),
        .rst_n   (presetn),
        .ce      (ce && out_ce),
        .use_reg (ctrl[`EMB_CTRL_OREG]),
        .d       ({hit, rd_c}),
        .q       (o_q)
    );

    assign user_rvalid = o_q[8];
    assign user_rdata  = o_q[7:0];

    AST_WRITE_STORES: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_go && !(pre_wr && pre_addr == wbyte)) |=>
            mem[$past(wbyte)] == merge($past(mem[wbyte]), $past(d_q), $past(shape),
                                       $past(a_addr)))
        else $error("user write not stored");

    AST_ROM_LOCK: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl[`EMB_CTRL_ROM] && !pre_wr) |=> $stable(wcount))
        else $error("write taken in rom mode");

    AST_PRELOAD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && pre_wr) |=> (mem[$past(pre_addr)] == $past(pwdata[7:0]) &&
                            pre_addr == $past(pre_addr) + 8'h01))
        else $error("preload byte not stored");

    AST_OUT_REG_DELAY: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && out_ce && ctrl[`EMB_CTRL_OREG] && !apb_wr) |=>
            (user_rdata == $past(rd_c) && user_rvalid == $past(hit)))
        else $error("output register did not delay read by one cycle");

    AST_READ_OLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_go && out_ce && ctrl[`EMB_CTRL_OREG] && !apb_wr) |=>
            user_rdata == pick($past(mem[wbyte]), $past(shape), $past(a_addr)))
        else $error("read during write did not return old value");

    AST_BYPASS: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!ctrl[`EMB_CTRL_OREG] && !ctrl[`EMB_CTRL_AREG]) |->
            user_rvalid == (user_bank == ctrl[`EMB_CTRL_BANK_HI:`EMB_CTRL_BANK_LO]))
        else $error("bypassed path not transparent");

    AST_MISS_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        !user_rvalid |-> user_rdata == 8'h00)
        else $error("missed bank drives read data");

    AST_SHAPE_WIDTH: assert property (
        @(posedge pclk) disable iff (!presetn)
        (shape == SHAPE_2048X1 |-> rd_c[7:1] == 7'h00) and
        (shape == SHAPE_512X4 |-> rd_c[7:4] == 4'h0))
        else $error("read wider than selected shape");

    AST_IN_FREEZE: assert property (
        @(posedge pclk) disable iff (!presetn)
        !in_ce |=> $stable(wcount))
        else $error("write taken with input side frozen");

    AST_APB_ANSWER: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && !penable) ##1 (ce && psel && penable) |-> pready)
        else $error("apb access not answered in first access cycle");
endmodule : embedded_memory_block

// ==== bench/user_logic_model.sv ====
`timescale 1ns/1ps
module user_logic_model (
    input  wire logic          pclk,
    output logic               in_ce,
    output logic               out_ce,
    output logic               user_we,
    output logic [2:0]         user_bank,
    output logic [10:0]        user_addr,
    output emb_ram_pkg::byte_t user_wdata
);
    import emb_ram_pkg::*;
    initial begin
        in_ce      = 1'b1;
        out_ce     = 1'b1;
        user_we    = 1'b0;
        user_bank  = 3'h0;
        user_addr  = 11'h000;
        user_wdata = 8'h00;
    end
    // side enables stand in for the two clocks, no wait of their own
    task automatic enables(input logic i, input logic o);
        in_ce  <= i;
        out_ce <= o;
    endtask : enables
    // one request a cycle, changed just after a rising edge
    task automatic put(input logic we, input logic [2:0] b, input logic [10:0] a, input byte_t d);
        user_we    <= we;
        user_bank  <= b;
        user_addr  <= a;
        user_wdata <= we ? d : ~user_wdata; // idle data toggles so stale bytes never match
        @(posedge pclk);
    endtask : put
endmodule : user_logic_model

// ==== bench/configurable_embedded_ram_bench.sv ====
`timescale 1ns/1ps
`include "emb_ram_params.svh"
module configurable_embedded_ram_bench;
    import emb_ram_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ce;
    logic        in_ce, out_ce, user_we, user_rvalid;
    logic [2:0]  user_bank;
    logic [10:0] user_addr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, seed;
    byte_t       user_wdata, user_rdata, dv;
    byte_t       mem [256];
    int          err_total, compares, s, a, k, nw;

    embedded_memory_block u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_ce(in_ce), .out_ce(out_ce),
        .user_we(user_we), .user_bank(user_bank), .user_addr(user_addr),
        .user_wdata(user_wdata), .user_rdata(user_rdata), .user_rvalid(user_rvalid));
    user_logic_model u_user (.pclk(pclk), .in_ce(in_ce), .out_ce(out_ce), .user_we(user_we),
        .user_bank(user_bank), .user_addr(user_addr), .user_wdata(user_wdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic byte_t exp_rd(input int ad);
        return byte_t'((mem[ad >> s] >> ((ad % (1 << s)) * (8 >> s))) & ((1 << (8 >> s)) - 1));
    endfunction : exp_rd
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
        compares++;
        if (y !== x) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, x, y);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        logic ok;
        ok = 1'b0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // ready, error and data are all taken at the rising edge that ends the access
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge pclk);
            {e, q} = {pslverr, prdata};
            ok = (pready === 1'b1);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            err_total++;
            close_out();
        end
        @(posedge pclk);
    endtask : apb
    task automatic wr(input int ad, input byte_t dd);
        int l;
        int m;
        l = (ad % (1 << s)) * (8 >> s);
        m = (1 << (8 >> s)) - 1;
        u_user.put(1'b1, 3'h0, 11'(ad), dd);
        mem[ad >> s] = byte_t'((mem[ad >> s] & ~(m << l)) | ((dd & m) << l));
        nw++;
    endtask : wr
    task automatic rd(input logic [2:0] b, input int ad, input logic [8:0] x);
        u_user.put(1'b0, b, 11'(ad), 8'h00);
        @(negedge pclk);
        chk("user_rdata", {23'h0, x}, {23'h0, user_rvalid, user_rdata});
        @(posedge pclk);
    endtask : rd

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        {err_total, compares, nw, s} = '0;
        seed = 32'h00002841;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `EMB_REG_CTRL, 32'h0);
        chk("ctrl", 32'h0, q);
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        apb(1'b1, `EMB_REG_PRELOAD_ADDR, 32'h0);
        for (a = 0; a < 256; a++) begin
            mem[a] = byte_t'(rnd());
            apb(1'b1, `EMB_REG_PRELOAD_DATA, {24'h0, mem[a]});
        end
        apb(1'b0, `EMB_REG_PRELOAD_DATA, 32'h0);
        chk("preload_data", {24'h0, mem[0]}, q);
        chk("pslverr_mapped", 32'h0, {31'h0, e});
        $display("test preload done");
        for (s = 0; s < 4; s++) begin
            apb(1'b1, `EMB_REG_CTRL, 32'(s));
            for (k = 0; k < 8; k++) begin
                a = int'(rnd() % (256 << s));
                wr(a, byte_t'(rnd()));
                rd(3'h0, a, {1'b1, exp_rd(a)});
                rd(3'h0, a ^ 1, {1'b1, exp_rd(a ^ 1)});
            end
        end
        $display("test shapes done");
        apb(1'b0, `EMB_REG_STATUS, 32'h0);
        chk("status", 32'(nw), q);
        s = 0;
        a = int'(rnd() % 256);
        dv = ~mem[a];
        apb(1'b1, `EMB_REG_CTRL, 32'h140);
        u_user.put(1'b1, 3'h2, 11'(a), dv);
        rd(3'h2, a, 9'h000);
        rd(3'h5, a, {1'b1, mem[a]});
        apb(1'b1, `EMB_REG_CTRL, 32'h020);
        u_user.put(1'b1, 3'h0, 11'(a), dv);
        rd(3'h0, a, {1'b1, mem[a]});
        apb(1'b1, `EMB_REG_CTRL, 32'h0);
        u_user.enables(1'b0, 1'b1);
        u_user.put(1'b1, 3'h0, 11'(a), dv);
        u_user.enables(1'b1, 1'b1);
        rd(3'h0, a, {1'b1, mem[a]});
        ce <= 1'b0;
        u_user.put(1'b1, 3'h0, 11'(a), dv);
        ce <= 1'b1;
        rd(3'h0, a, {1'b1, mem[a]});
        apb(1'b0, `EMB_REG_STATUS, 32'h0);
        chk("status_refused", 32'(nw), q);
        $display("test refusals done");
        apb(1'b1, `EMB_REG_CTRL, 32'h01c);
        u_user.put(1'b1, 3'h0, 11'(a), dv);
        u_user.put(1'b0, 3'h0, 11'(a), dv);
        @(negedge pclk);
        chk("read_during_write", {24'h0, mem[a]}, {24'h0, user_rdata});
        @(posedge pclk);
        u_user.enables(1'b1, 1'b0);
        @(negedge pclk);
        chk("stage_write", {24'h0, dv}, {24'h0, user_rdata});
        @(posedge pclk);
        u_user.put(1'b0, 3'h0, 11'(a ^ 1), dv);
        @(negedge pclk);
        chk("out_hold", {24'h0, dv}, {24'h0, user_rdata});
        $display("test stages done");
        close_out();
    end
endmodule : configurable_embedded_ram_bench
